// *** hdl/exception_pkg.sv ***
// constants and types shared by the exception arbiter files
package exception_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses, one 32-bit word each)
	// ------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam logic [ADDR_W-1:0] PENDING_LOW_OFFSET = 16'hfe04;
	localparam logic [ADDR_W-1:0] PENDING_HIGH_OFFSET = 16'hfe08;
	localparam logic [ADDR_W-1:0] MASK_CTRL_OFFSET = 16'hfe0c;
	localparam logic [ADDR_W-1:0] ARB_STATUS_OFFSET = 16'hfe10;

	localparam logic [7:0] PENDING_LOW_RESET = 8'h00;
	localparam logic [7:0] PENDING_HIGH_RESET = 8'h00;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

	// pending_low: groups 6..1 in bits 7..2, bits 1..0 read zero
	localparam int PENDING_LOW_SHIFT = 2;
	// mask_ctrl: bit 0 is the global interrupt mask
	localparam int MASK_BIT = 0;
	localparam logic MASK_RESET = 1'b1;
	// arb_status: bit 0 latched, bits 7..4 winning source
	localparam int STATUS_LATCHED_BIT = 0;
	localparam int STATUS_WINNER_LSB = 4;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ------------------------------------------------------------
	// sources: index 0 is the software trap, 1..14 hardware groups
	// ------------------------------------------------------------
	localparam int NUM_SRC = 15;
	localparam int SRC_W = 4;
	localparam logic [SRC_W-1:0] SRC_SOFTWARE_TRAP = 4'h0;

	localparam logic [15:0] RESET_VECTOR = 16'hfffe;
	localparam logic [15:0] VECTOR_TABLE [0:NUM_SRC-1] = '{
		16'hfffc, 16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4,
		16'hfff2, 16'hfff0, 16'hffee, 16'hffec, 16'hffea,
		16'hffe8, 16'hffe6, 16'hffe4, 16'hffe2, 16'hffe0
	};

	typedef enum logic [1:0] {
		ARB_IDLE = 2'b00,
		ARB_HELD = 2'b01
	} arb_state_type;

endpackage

// *** hdl/arb_if.sv ***
// carrier between the exception arbiter top and its priority latch
`timescale 1ns/10ps
interface arb_if;
	import exception_pkg::*;
	logic [NUM_SRC-1:0] req;
	logic external_pin_mask;
	logic boundary;
	logic serviced;
	logic release_latch;
	logic start;
	logic latched;
	logic [SRC_W-1:0] winner;
	logic [15:0] vector;
	logic pc_minus_one;

	modport top(output req, output external_pin_mask, output boundary, output serviced, output release_latch,
		input start, input latched, input winner, input vector, input pc_minus_one);
	modport arb(input req, input external_pin_mask, input boundary, input serviced, input release_latch,
		output start, output latched, output winner, output vector, output pc_minus_one);
endinterface

// *** hdl/priority_latch.sv ***
// latches the winning request and holds it until it is serviced or the mask is cleared
`timescale 1ns/10ps
module priority_latch (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// arbitration carrier
	arb_if.arb arb
);
	import exception_pkg::*;

	arb_state_type state_r;
	logic [SRC_W-1:0] winner_r;
	logic [15:0] vector_r;
	logic pc_minus_one_r;
	logic start_r;
	logic [NUM_SRC-1:0] eligible;
	logic take;
	logic [SRC_W-1:0] sel;

	// lowest index wins; index 0 is the software trap
	function automatic logic [SRC_W-1:0] lowest(input logic [NUM_SRC-1:0] v);
		logic [SRC_W-1:0] idx;
		idx = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = SRC_W'(i);
			end
		end
		return idx;
	endfunction

	always_comb begin
		// global mask gates every hardware group, never the trap
		eligible = arb.req & {{(NUM_SRC-1){~arb.external_pin_mask}}, 1'b1};
		// hardware only at an instruction boundary; the trap is itself an instruction
		take = (state_r == ARB_IDLE) && (arb.req[0] || (arb.boundary && (|eligible[NUM_SRC-1:1])));
		sel = lowest(eligible);
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_r <= ARB_IDLE;
		end else begin
			case (state_r)
				ARB_IDLE: begin
					if (take) begin
						state_r <= ARB_HELD;
					end
				end
				ARB_HELD: begin
					// nothing pre-empts a held request until service or mask clear
					if (arb.serviced || arb.release_latch) begin
						state_r <= ARB_IDLE;
					end
				end
				default: begin
					state_r <= ARB_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			winner_r <= SRC_SOFTWARE_TRAP;
			vector_r <= RESET_VECTOR;
			pc_minus_one_r <= 1'b0;
			start_r <= 1'b0;
		end else begin
			start_r <= take;
			if (take) begin
				winner_r <= sel;
				vector_r <= VECTOR_TABLE[sel];
				pc_minus_one_r <= (sel != SRC_SOFTWARE_TRAP);
			end
		end
	end

	assign arb.start = start_r;
	assign arb.latched = (state_r == ARB_HELD);
	assign arb.winner = winner_r;
	assign arb.vector = vector_r;
	assign arb.pc_minus_one = pc_minus_one_r;
endmodule

// *** hdl/exception_interrupt_arbiter.sv ***
// exception control: request grouping, global mask, arbitration and status registers
//
// Overview of operation
// - pending requests are latched and arbitrated when interrupt processing starts.
// - the winner is handed to the core as a constant selecting its vector.
// - a latched request is never pre-empted until serviced or mask cleared.
// - on entry the core stacks registers and the global mask gets set.
// - return-from-trap restores the stacked registers, including the mask.
// - hardware requests are taken only at instruction boundaries.
// - a hardware request starts processing only if mask clear and its enable set.
// - lowest priority number wins; 0 highest, keyboard 14 lowest.
// - a request pending at return is serviced before the next program instruction.
// - the high index register is never stacked; handlers save it themselves.
// - the software trap instruction is taken whatever the mask.
// - trap stacks pc, hardware stacks pc minus one; trap vector fffc.
// - the global mask gates all sources except the software trap.
// - eight serial-bus function sources share flag 1, priority 1, vector fffa.
// - external pin and port E bit 4 share flag 2, vector fff8, masked.
// - serial error sources share flag 11, each with its own enable.
// - receive sources share flag 12 at ffe4; transmit share 13 at ffe2.
// - keyboard maps to flag 14, vector ffe0, gated by keyboard mask.
// - pending_low at fe04 shows groups 6..1 in bits 7..2, read-only.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module exception_interrupt_arbiter (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,

	// axi4-lite write address channel
	input wire logic [exception_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	// axi4-lite write data channel
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	// axi4-lite write response channel
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// axi4-lite read address channel
	input wire logic [exception_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	// axi4-lite read data channel
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,

	// serial-bus function sources: flags and enables
	input wire logic [7:0] usb_flag_i,
	input wire logic [7:0] usb_enable_i,
	// external pin and port E bit 4
	input wire logic irq_pin_flag_i,
	input wire logic port_e_bit4_flag_i,
	input wire logic external_pin_mask_i,
	// timer 1 and timer 2: ch0, ch1, ch0-and-1, overflow
	input wire logic [3:0] timer1_flag_i,
	input wire logic [3:0] timer1_enable_i,
	input wire logic [3:0] timer2_flag_i,
	input wire logic [3:0] timer2_enable_i,
	// serial interface: overrun, noise, framing, parity
	input wire logic [3:0] sci_error_flag_i,
	input wire logic [3:0] sci_error_enable_i,
	// serial interface: receiver full, idle line
	input wire logic [1:0] sci_rx_flag_i,
	input wire logic [1:0] sci_rx_enable_i,
	// serial interface: transmitter empty, transmission complete
	input wire logic [1:0] sci_tx_flag_i,
	input wire logic [1:0] sci_tx_enable_i,
	// keyboard
	input wire logic keyboard_flag_i,
	input wire logic keyboard_mask_i,

	// cpu core events
	input wire logic instr_boundary_i,
	input wire logic software_trap_instruction_i,
	input wire logic vector_fetched_i,
	input wire logic return_from_trap_instruction_i,
	input wire logic restored_mask_i,

	// cpu core controls
	output logic int_start_o,
	output logic [exception_pkg::SRC_W-1:0] vector_sel_o,
	output logic [15:0] vector_addr_o,
	output logic stack_pc_minus_one_o,
	output logic stack_index_high_o,
	output logic global_mask_o
);
	import exception_pkg::*;

	// ------------------------------------------------------------
	// per-source requests
	// ------------------------------------------------------------
	// a source requests only while its flag and its own enable are set; the keyboard and the pin pair need their mask clear instead
	logic [7:0] usb_req;
	logic [1:0] pin_req;
	logic [3:0] timer1_req;
	logic [3:0] timer2_req;
	logic [3:0] sci_error_req;
	logic [1:0] sci_rx_req;
	logic [1:0] sci_tx_req;
	logic keyboard_req;

	assign usb_req = usb_flag_i & usb_enable_i;
	// the pin pair shares one mask bit, so either pin alone raises its group
	assign pin_req = {irq_pin_flag_i, port_e_bit4_flag_i} & {2{~external_pin_mask_i}};
	assign timer1_req = timer1_flag_i & timer1_enable_i;
	assign timer2_req = timer2_flag_i & timer2_enable_i;
	assign sci_error_req = sci_error_flag_i & sci_error_enable_i;
	assign sci_rx_req = sci_rx_flag_i & sci_rx_enable_i;
	assign sci_tx_req = sci_tx_flag_i & sci_tx_enable_i;
	assign keyboard_req = keyboard_flag_i & ~keyboard_mask_i;

	// ------------------------------------------------------------
	// source grouping
	// ------------------------------------------------------------
	logic [NUM_SRC-1:1] pending_group_flags;

	always_comb begin
		// each group flag is the live OR of its enabled sources
		pending_group_flags[1] = |usb_req;
		pending_group_flags[2] = |pin_req;
		// timer groups hold one source each
		for (int i = 0; i < 4; i++) begin
			pending_group_flags[3 + i] = timer1_req[i];
			pending_group_flags[7 + i] = timer2_req[i];
		end
		pending_group_flags[11] = |sci_error_req;
		pending_group_flags[12] = |sci_rx_req;
		pending_group_flags[13] = |sci_tx_req;
		pending_group_flags[14] = keyboard_req;
	end

	// ------------------------------------------------------------
	// axi4-lite write path
	// ------------------------------------------------------------
	logic aw_held_r;
	logic w_held_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic write_fire;
	logic write_mapped;
	logic mask_write_clear;
	logic mask_write_set;

	// both readies fall while a response waits, so one write is in flight
	assign s_axi_awready_o = ~aw_held_r & ~bvalid_r;
	assign s_axi_wready_o = ~w_held_r & ~bvalid_r;
	assign write_fire = aw_held_r & w_held_r & ~bvalid_r;

	always_comb begin
		// the status registers accept the write but keep their value
		case (awaddr_r)
			PENDING_LOW_OFFSET,
			PENDING_HIGH_OFFSET,
			MASK_CTRL_OFFSET,
			ARB_STATUS_OFFSET: write_mapped = 1'b1;
			default: write_mapped = 1'b0;
		endcase
	end

	// address and data may come in either order; each is parked until both are in
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			aw_held_r <= 1'b0;
			awaddr_r <= '0;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_held_r <= 1'b1;
			awaddr_r <= s_axi_awaddr_i;
		end else if (write_fire) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			w_held_r <= 1'b0;
			wdata_r <= DATA_ZERO;
			wstrb_r <= 4'h0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_held_r <= 1'b1;
			wdata_r <= s_axi_wdata_i;
			wstrb_r <= s_axi_wstrb_i;
		end else if (write_fire) begin
			w_held_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// write response
	// ------------------------------------------------------------
	// unmapped addresses answer with an error and change nothing
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else if (write_fire) begin
			bvalid_r <= 1'b1;
			bresp_r <= write_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			bvalid_r <= 1'b0;
		end
	end

	assign s_axi_bvalid_o = bvalid_r;
	assign s_axi_bresp_o = bresp_r;

	// ------------------------------------------------------------
	// mask register write decode
	// ------------------------------------------------------------
	logic write_to_mask;

	// only the low byte lane carries the mask bit
	assign write_to_mask = write_fire && (awaddr_r == MASK_CTRL_OFFSET) && wstrb_r[0];
	assign mask_write_clear = write_to_mask && !wdata_r[MASK_BIT];
	assign mask_write_set = write_to_mask && wdata_r[MASK_BIT];

	// ------------------------------------------------------------
	// global interrupt mask
	// ------------------------------------------------------------
	logic global_mask_r;
	logic mask_clear_event;

	// declared ahead of the arbitration section because the mask reads the start pulse
	arb_if arb_bus ();

	// a clear, by write or by return, also frees a held latch
	assign mask_clear_event = mask_write_clear || (return_from_trap_instruction_i && !restored_mask_i);

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			global_mask_r <= MASK_RESET;
		end else if (arb_bus.start) begin
			// entry sets the mask and wins over a clear in the same cycle
			global_mask_r <= 1'b1;
		end else if (return_from_trap_instruction_i) begin
			// a restored clear lets a still pending request in at the next boundary
			global_mask_r <= restored_mask_i;
		end else if (mask_write_clear) begin
			global_mask_r <= 1'b0;
		end else if (mask_write_set) begin
			global_mask_r <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// arbitration
	// ------------------------------------------------------------
	assign arb_bus.req = {pending_group_flags, software_trap_instruction_i};
	assign arb_bus.external_pin_mask = global_mask_r;
	assign arb_bus.boundary = instr_boundary_i;
	// the vector fetch counts as service; the latch holds until then or until a mask clear
	assign arb_bus.serviced = vector_fetched_i;
	assign arb_bus.release_latch = mask_clear_event;

	priority_latch u_priority_latch (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.arb(arb_bus.arb)
	);

	// ------------------------------------------------------------
	// core controls
	// ------------------------------------------------------------
	// these four come from latch flip-flops, so the core sees no glitch
	assign int_start_o = arb_bus.start;
	assign vector_sel_o = arb_bus.winner;
	assign vector_addr_o = arb_bus.vector;
	assign stack_pc_minus_one_o = arb_bus.pc_minus_one;
	// the high index register is left to the handler
	assign stack_index_high_o = 1'b0;
	assign global_mask_o = global_mask_r;

	// ------------------------------------------------------------
	// axi4-lite read path
	// ------------------------------------------------------------
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic [31:0] read_word;
	logic read_mapped;

	// a new address is taken only once the previous answer has gone out
	assign s_axi_arready_o = ~rvalid_r;

	// ------------------------------------------------------------
	// read decode
	// ------------------------------------------------------------
	// decoded from the live address; the word is captured at the handshake edge
	always_comb begin
		read_word = DATA_ZERO;
		read_mapped = 1'b1;
		case (s_axi_araddr_i)
			PENDING_LOW_OFFSET: begin
				read_word[7:0] = {pending_group_flags[6:1], 2'b00} | PENDING_LOW_RESET;
			end
			PENDING_HIGH_OFFSET: begin
				read_word[7:0] = pending_group_flags[14:7] | PENDING_HIGH_RESET;
			end
			MASK_CTRL_OFFSET: begin
				read_word[MASK_BIT] = global_mask_r;
			end
			ARB_STATUS_OFFSET: begin
				read_word[STATUS_LATCHED_BIT] = arb_bus.latched;
				read_word[STATUS_WINNER_LSB +: SRC_W] = arb_bus.winner;
			end
			default: begin
				read_mapped = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// read response
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			rvalid_r <= 1'b0;
			rdata_r <= DATA_ZERO;
			rresp_r <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_r <= 1'b1;
			rdata_r <= read_word;
			rresp_r <= read_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready_i) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_rvalid_o = rvalid_r;
	assign s_axi_rdata_o = rdata_r;
	assign s_axi_rresp_o = rresp_r;
endmodule

// *** verif/exception_arbiter_properties.sv ***
// concurrent checks on the exception arbiter top ports
`timescale 1ns/10ps
module exception_arbiter_properties
	import exception_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// register read channel
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	// sources of groups 1 to 6
	input wire logic [7:0] usb_flag_i,
	input wire logic [7:0] usb_enable_i,
	input wire logic irq_pin_flag_i,
	input wire logic port_e_bit4_flag_i,
	input wire logic external_pin_mask_i,
	input wire logic [3:0] timer1_flag_i,
	input wire logic [3:0] timer1_enable_i,
	// core side
	input wire logic instr_boundary_i,
	input wire logic software_trap_instruction_i,
	input wire logic int_start_o,
	input wire logic [SRC_W-1:0] vector_sel_o,
	input wire logic [15:0] vector_addr_o,
	input wire logic stack_pc_minus_one_o,
	input wire logic stack_index_high_o,
	input wire logic global_mask_o
);
	import exception_pkg::*;
	// ----------------------------------------
	// helpers and properties
	// ----------------------------------------
	// groups 6..1 worked out from the sources, not from the design
	logic [5:0] low_grp;
	assign low_grp = {timer1_flag_i & timer1_enable_i,
		(irq_pin_flag_i | port_e_bit4_flag_i) & ~external_pin_mask_i, |(usb_flag_i & usb_enable_i)};
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	sequence s_rd_low; s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == PENDING_LOW_OFFSET; endsequence
	sequence s_hw_start; int_start_o && vector_sel_o != SRC_SOFTWARE_TRAP; endsequence
	property p_pending_low; s_rd_low |=> s_axi_rdata_o == {24'h00_0000, $past(low_grp), 2'b00}; endproperty
	a_pending_low: assert property (p_pending_low) else $error("pending_low read wrong");
	property p_start_cause; int_start_o |-> $past(instr_boundary_i) || $past(software_trap_instruction_i); endproperty
	a_start_cause: assert property (p_start_cause) else $error("start without boundary or trap");
	property p_trap_vec; int_start_o && vector_sel_o == SRC_SOFTWARE_TRAP |-> vector_addr_o == 16'hfffc && !stack_pc_minus_one_o; endproperty
	a_trap_vec: assert property (p_trap_vec) else $error("trap vector or stacking wrong");
	property p_hw_vec; s_hw_start |-> stack_pc_minus_one_o && vector_addr_o == 16'hfffc - {11'h000, vector_sel_o, 1'b0}; endproperty
	a_hw_vec: assert property (p_hw_vec) else $error("hardware vector wrong");
	property p_hw_gate; s_hw_start |-> !$past(global_mask_o) && $past(instr_boundary_i); endproperty
	a_hw_gate: assert property (p_hw_gate) else $error("hardware start while masked");
	property p_mask_entry; int_start_o |=> global_mask_o; endproperty
	a_mask_entry: assert property (p_mask_entry) else $error("mask not set on entry");
	property p_no_index; stack_index_high_o == 1'b0; endproperty
	a_no_index: assert property (p_no_index) else $error("high index stacked");
	property p_no_preempt; s_hw_start |=> !int_start_o [*2]; endproperty
	a_no_preempt: assert property (p_no_preempt) else $error("latched request pre-empted");
endmodule

// *** verif/cpu_core_model.sv ***
// behavioural core: fetches the vector, runs a handler, returns
`timescale 1ns/10ps
module cpu_core_model (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// arbiter side
	input wire logic int_start_i,
	input wire logic global_mask_i,
	input wire logic slow_i,
	output logic vector_fetched_o,
	output logic return_o,
	output logic restored_mask_o
);
	logic [3:0] wait_r;
	logic stacked_mask_r;
	// ----------------------------------------
	// handler timing
	// ----------------------------------------
	// a slow handler keeps the latch held longer, to expose pre-emption
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			wait_r <= 4'h0;
			vector_fetched_o <= 1'b0;
			return_o <= 1'b0;
		end else begin
			vector_fetched_o <= 1'b0;
			return_o <= 1'b0;
			if (int_start_i) begin
				wait_r <= slow_i ? 4'h6 : 4'h2;
			end else if (wait_r != 4'h0) begin
				wait_r <= wait_r - 4'h1;
				vector_fetched_o <= (wait_r == 4'h2);
				return_o <= (wait_r == 4'h1);
			end
		end
	end
	// only the mask is kept; the high index byte is left to the handler
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			stacked_mask_r <= 1'b1;
		end else if (int_start_i) begin
			stacked_mask_r <= global_mask_i;
		end
	end
	assign restored_mask_o = stacked_mask_r;
endmodule

// *** verif/exception_interrupt_arbiter_test.sv ***
// self-checking bench for the exception arbiter
`timescale 1ns/10ps
module exception_interrupt_arbiter_test;
	import exception_pkg::*;
	logic ref_clk_i, reset_i, slow;
	logic [15:0] s_axi_awaddr_i, s_axi_araddr_i, vector_addr_o;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
	logic [3:0] s_axi_wstrb_i, vector_sel_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
	logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
	logic [7:0] usb_flag_i, usb_enable_i;
	logic irq_pin_flag_i, port_e_bit4_flag_i, external_pin_mask_i, keyboard_flag_i, keyboard_mask_i;
	logic [3:0] timer1_flag_i, timer1_enable_i, timer2_flag_i, timer2_enable_i, sci_error_flag_i, sci_error_enable_i;
	logic [1:0] sci_rx_flag_i, sci_rx_enable_i, sci_tx_flag_i, sci_tx_enable_i;
	logic instr_boundary_i, software_trap_instruction_i, vector_fetched_i, return_from_trap_instruction_i;
	logic restored_mask_i, int_start_o, stack_pc_minus_one_o, stack_index_high_o, global_mask_o;
	int n_mismatch, tests_run;
	exception_interrupt_arbiter exception_interrupt_arbiter_i (.*);
	cpu_core_model cpu_core_model_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .int_start_i(int_start_o),
		.global_mask_i(global_mask_o), .slow_i(slow), .vector_fetched_o(vector_fetched_i),
		.return_o(return_from_trap_instruction_i), .restored_mask_o(restored_mask_i));
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task end_of_test;
		if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
		do begin
			@(posedge ref_clk_i);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
		end while (s_axi_bvalid_o !== 1'b1);
		s_axi_bready_i <= 1'b0;
		check("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp_o));
	endtask
	task rd(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge ref_clk_i);
		s_axi_araddr_i <= a;
		{s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
		do begin
			@(posedge ref_clk_i);
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
		end while (s_axi_rvalid_o !== 1'b1);
		s_axi_rready_i <= 1'b0;
		check("rdata", d, s_axi_rdata_o);
		check("rresp", 32'(r), 32'(s_axi_rresp_o));
	endtask
	task set_grp(input int g, input logic v);
		case (g)
			1: usb_flag_i[3] <= v;
			2: {irq_pin_flag_i, port_e_bit4_flag_i} <= {v, v};
			3, 4, 5, 6: timer1_flag_i[g-3] <= v;
			7, 8, 9, 10: timer2_flag_i[g-7] <= v;
			11: sci_error_flag_i[2] <= v;
			12: sci_rx_flag_i[1] <= v;
			13: sci_tx_flag_i[0] <= v;
			default: keyboard_flag_i <= v;
		endcase
	endtask
	task set_en(input logic v);
		{usb_enable_i, timer1_enable_i, timer2_enable_i, sci_error_enable_i, sci_rx_enable_i, sci_tx_enable_i} <= {24{v}};
		{external_pin_mask_i, keyboard_mask_i} <= {2{!v}};
	endtask
	task pulse(input logic trap);
		@(posedge ref_clk_i);
		if (trap) software_trap_instruction_i <= 1'b1;
		else instr_boundary_i <= 1'b1;
		@(posedge ref_clk_i);
		{software_trap_instruction_i, instr_boundary_i} <= 2'h0;
	endtask
	// group 0 stands for the software trap
	task svc(input int g);
		pulse(g == 0);
		@(negedge ref_clk_i);
		check("start", 1, 32'(int_start_o));
		check("sel", g, 32'(vector_sel_o));
		check("addr", 32'(16'hfffc - 16'(2 * g)), 32'(vector_addr_o));
		check("pcm1", 32'(g != 0), 32'(stack_pc_minus_one_o));
		@(negedge ref_clk_i);
		check("mask", 1, 32'(global_mask_o));
	endtask
	task quiet(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge ref_clk_i);
			check("idle", 0, 32'(int_start_o));
		end
	endtask
	task unmask;
		for (int i = 0; i < 40 && global_mask_o !== 1'b0; i++) @(negedge ref_clk_i);
		check("unmask", 0, 32'(global_mask_o));
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		reset_i = 1'b1;
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
		s_axi_wstrb_i = 4'hf;
		{usb_flag_i, irq_pin_flag_i, port_e_bit4_flag_i, timer1_flag_i, timer2_flag_i} = '0;
		{sci_error_flag_i, sci_rx_flag_i, sci_tx_flag_i, keyboard_flag_i} = '0;
		{instr_boundary_i, software_trap_instruction_i, slow} = '0;
		set_en(1'b1);
		repeat (2) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		rd(PENDING_LOW_OFFSET, 32'h0000_0000, RESP_OKAY);
		rd(MASK_CTRL_OFFSET, 32'h0000_0001, RESP_OKAY);
		rd(16'h0100, 32'h0000_0000, RESP_SLVERR);
		@(posedge ref_clk_i);
		for (int g = 1; g < 15; g++) set_grp(g, 1'b1);
		rd(PENDING_LOW_OFFSET, 32'h0000_00fc, RESP_OKAY);
		wr(PENDING_LOW_OFFSET, 32'h0000_0000);
		rd(PENDING_LOW_OFFSET, 32'h0000_00fc, RESP_OKAY);
		rd(PENDING_HIGH_OFFSET, 32'h0000_00ff, RESP_OKAY);
		pulse(1'b0);
		quiet(3);
		wr(MASK_CTRL_OFFSET, 32'h0000_0000);
		for (int g = 1; g < 15; g++) begin
			svc(g);
			@(posedge ref_clk_i);
			set_grp(g, 1'b0);
			unmask();
		end
		@(posedge ref_clk_i);
		for (int g = 1; g < 15; g++) set_grp(g, 1'b1);
		set_en(1'b0);
		rd(PENDING_LOW_OFFSET, 32'h0000_0000, RESP_OKAY);
		rd(PENDING_HIGH_OFFSET, 32'h0000_0000, RESP_OKAY);
		pulse(1'b0);
		quiet(3);
		wr(MASK_CTRL_OFFSET, 32'h0000_0001);
		svc(0);
		repeat (8) @(negedge ref_clk_i);
		check("mask", 1, 32'(global_mask_o));
		@(posedge ref_clk_i);
		slow <= 1'b1;
		set_en(1'b1);
		for (int g = 1; g < 15; g++) set_grp(g, g == 5);
		wr(MASK_CTRL_OFFSET, 32'h0000_0000);
		svc(5);
		rd(ARB_STATUS_OFFSET, 32'h0000_0051, RESP_OKAY);
		set_grp(1, 1'b1);
		pulse(1'b1);
		quiet(2);
		@(posedge ref_clk_i);
		set_grp(5, 1'b0);
		unmask();
		svc(1);
		end_of_test();
	end
	initial begin
		repeat (4000) @(posedge ref_clk_i);
		n_mismatch++;
		end_of_test();
	end
endmodule
bind exception_interrupt_arbiter exception_arbiter_properties exception_arbiter_properties_i (.*);
